// >>> common/fault_irq_map.svh
// register indices, field layouts, reset values and timing for the fault interrupt block
`ifndef FAULT_IRQ_MAP_SVH
`define FAULT_IRQ_MAP_SVH
// register indices; the byte address is four times the index
`define IDX_RATIO_UPPER 8'h40
`define IDX_RATIO_LOWER 8'h41
`define IDX_INT_CFG 8'h42
`define IDX_DAC_CFG 8'h43
`define IDX_SRC_LIVE 8'h44
`define IDX_SRC_LATCH 8'h45
`define IDX_SRC_MASK 8'h46
`define IDX_PWR_CTRL 8'h47
// reset values
`define INT_CFG_RST 8'h00
`define DAC_CFG_RST 8'h50
`define SRC_MASK_RST 8'h00
`define RATIO_LOWER_RST 8'h00
// writable bits of the dac fault configuration
`define DAC_CFG_WMASK 8'h77
// source bit positions
`define SRC_ADC 0
`define SRC_MICBIAS 1
`define SRC_DAC_GATE 2
`define SRC_DAC_SHORT 3
`define SRC_ANALOG_REGULATOR_SHORT 4
// source groups that steer the power-down logic
`define ADC_GROUP 8'h03
`define DAC_GROUP 8'h0c
// power control register bits
`define PWR_ADC_BIT 0
`define PWR_DAC_BIT 1
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// timing
`define CLK_MHZ 100
`define IRQ_PULSE_US 2000
`define IRQ_PERIOD_US 4000
`endif

// >>> common/fault_irq_pkg.sv
// types shared by the fault interrupt and power-down block
package fault_irq_pkg;
  typedef enum logic [1:0] {
    PD_NONE = 2'h0,
    PD_UNMASKED = 2'h1,
    PD_ALL = 2'h2,
    PD_RSVD = 2'h3
  } pd_sel_t;
  typedef enum logic [1:0] {
    IRQ_LATCHED = 2'h0,
    IRQ_LIVE = 2'h1,
    IRQ_REPEAT = 2'h2,
    IRQ_ONESHOT = 2'h3
  } irq_mode_t;
  typedef struct packed {
    logic pol;
    irq_mode_t mode;
    pd_sel_t adc_sel;
    logic latch_unmasked_only;
    logic adc_manual;
    logic clr_any;
  } int_cfg_t;
  typedef struct packed {
    logic rsvd;
    pd_sel_t sel;
    logic manual;
    logic down_flag;
    logic pu_mask;
    logic det_off;
    logic reg_off;
  } dac_cfg_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ON = 3'b010,
    ST_OFF = 3'b100
  } irq_state_t;
endpackage

// >>> hw/fault_interrupt_powerdown_ctrl.sv
// fault interrupt pin, latched status and fault power-down control with axi4-lite registers
//
// Contract
// - upper six ratio bits readable, read-only
// - lower ratio byte read-only, resets zero
// - polarity bit selects low or high active
// - modes 0/1: latched or live unmasked level
// - mode 2: 2 ms pulse every 4 ms
// - mode 3: one 2 ms pulse per event
// - adc selector: none, unmasked, all, reserved
// - latch readback all or unmasked only
// - adc auto recovery or stay down
// - read clears latch if live zero, or always; set wins over clear, so always also keeps bits that are live
// - dac selector same encoding, resets two
// - dac recovery manual by default
// - flag shows dac held down by fault
// - mask gate fault during dac power-up
// - dac gate/short detection can be disabled
// - regulator short detection can be disabled
`timescale 1ns/1ps
`include "fault_irq_map.svh"
module fault_interrupt_powerdown_ctrl #(
  parameter int N_SRC = 8,
  parameter int PULSE_CYC = `IRQ_PULSE_US * `CLK_MHZ,
  parameter int PERIOD_CYC = `IRQ_PERIOD_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_SRC-1:0] src_fault_in,
  input wire logic dac_powering_up_in,
  input wire logic [5:0] frame_ratio_upper_bits,
  input wire logic [7:0] frame_ratio_lower_bits,
  output logic irq_pin,
  output logic irq_level,
  output logic adc_powerdown,
  output logic micbias_powerdown,
  output logic dac_powerdown
);
  localparam logic [N_SRC-1:0] ADC_GRP = N_SRC'(`ADC_GROUP);
  localparam logic [N_SRC-1:0] DAC_GRP = N_SRC'(`DAC_GROUP);
  localparam logic [19:0] PULSE_END = 20'(PULSE_CYC - 1);
  localparam logic [19:0] PERIOD_END = 20'(PERIOD_CYC - 1);

  fault_irq_pkg::int_cfg_t int_cfg_reg;
  fault_irq_pkg::dac_cfg_t dac_cfg_reg;
  fault_irq_pkg::irq_state_t st_reg;
  fault_irq_pkg::irq_state_t st_next;
  logic [N_SRC-1:0] mask_reg;
  logic [N_SRC-1:0] latch_reg;
  logic [N_SRC-1:0] latch_next;
  logic [N_SRC-1:0] src_meta_reg;
  logic [N_SRC-1:0] src_sync_reg;
  logic [N_SRC-1:0] live;
  logic [N_SRC-1:0] live_d_reg;
  logic [N_SRC-1:0] det_en;
  logic [N_SRC-1:0] dac_trig;
  logic pu_meta_reg;
  logic pu_sync_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_idx_reg;
  logic aw_ok_reg;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic do_write;
  logic ar_take;
  logic [7:0] ar_idx;
  logic ar_ok;
  logic rd_clear;
  logic [7:0] rd_mux;
  logic adc_flt;
  logic dac_flt;
  logic adc_pd_reg;
  logic dac_pd_reg;
  logic adc_restart;
  logic dac_restart;
  logic new_evt;
  logic lat_any;
  logic live_any;
  logic irq_active;
  logic [19:0] cnt_reg;

  // address check: word aligned and one of the mapped indices
  function automatic logic addr_ok(input logic [9:0] a);
    logic [7:0] i;
    i = a[9:2];
    addr_ok = (a[1:0] == 2'h0) && (i >= `IDX_RATIO_UPPER) && (i <= `IDX_PWR_CTRL);
  endfunction

  // pin sources cross into the clock domain through two flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
      pu_meta_reg <= 1'b0;
      pu_sync_reg <= 1'b0;
      live_d_reg <= '0;
    end else if (ce) begin
      src_meta_reg <= src_fault_in;
      src_sync_reg <= src_meta_reg;
      pu_meta_reg <= dac_powering_up_in;
      pu_sync_reg <= pu_meta_reg;
      live_d_reg <= live;
    end
  end

  // detection disables gate the live condition itself, so nothing downstream sees it
  always_comb begin
    det_en = '1;
    det_en[`SRC_DAC_GATE] = ~dac_cfg_reg.det_off;
    det_en[`SRC_DAC_SHORT] = ~dac_cfg_reg.det_off;
    det_en[`SRC_ANALOG_REGULATOR_SHORT] = ~dac_cfg_reg.reg_off;
    live = src_sync_reg & det_en;
  end

  // axi handshakes and decode
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_ok = addr_ok(s_axi_araddr);
  assign rd_clear = ar_take && ar_ok && (ar_idx == `IDX_SRC_LATCH);
  assign adc_restart = do_write && aw_ok_reg && wlane_reg && (aw_idx_reg == `IDX_PWR_CTRL)
    && wdata_reg[`PWR_ADC_BIT];
  assign dac_restart = do_write && aw_ok_reg && wlane_reg && (aw_idx_reg == `IDX_PWR_CTRL)
    && wdata_reg[`PWR_DAC_BIT];

  // write address and data are taken independently, one write at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      aw_ok_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[9:2];
        aw_ok_reg <= addr_ok(s_axi_awaddr);
      end else if (!aw_full_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end else if (!w_full_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_ok_reg ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; only byte lane 0 carries data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_cfg_reg <= fault_irq_pkg::int_cfg_t'(`INT_CFG_RST);
      dac_cfg_reg <= fault_irq_pkg::dac_cfg_t'(`DAC_CFG_RST & `DAC_CFG_WMASK);
      mask_reg <= N_SRC'(`SRC_MASK_RST);
    end else if (ce && do_write && aw_ok_reg && wlane_reg) begin
      case (aw_idx_reg)
        `IDX_INT_CFG: int_cfg_reg <= fault_irq_pkg::int_cfg_t'(wdata_reg);
        // reserved and status bits are dropped; the host keeps bit 7 at zero
        `IDX_DAC_CFG: dac_cfg_reg <= fault_irq_pkg::dac_cfg_t'(wdata_reg & `DAC_CFG_WMASK);
        `IDX_SRC_MASK: mask_reg <= wdata_reg[N_SRC-1:0];
        default: begin
        end
      endcase
    end
  end

  // latched bits: a live condition sets, a read clears; set wins over clear
  generate
    for (genvar b = 0; b < N_SRC; b++) begin : g_latch
      always_comb begin
        latch_next[b] = live[b]
          | (latch_reg[b] & ~(rd_clear & (int_cfg_reg.clr_any | ~live[b])));
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_reg <= '0;
    end else if (ce) begin
      latch_reg <= latch_next;
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rd_mux = 8'h00;
    case (ar_idx)
      `IDX_RATIO_UPPER: rd_mux = {2'h0, frame_ratio_upper_bits};
      `IDX_RATIO_LOWER: rd_mux = frame_ratio_lower_bits;
      `IDX_INT_CFG: rd_mux = int_cfg_reg;
      // the flag follows the registered power-down output so it matches the channel itself
      `IDX_DAC_CFG: rd_mux = {1'b0, dac_cfg_reg.sel, dac_cfg_reg.manual, dac_powerdown,
        dac_cfg_reg.pu_mask, dac_cfg_reg.det_off, dac_cfg_reg.reg_off};
      `IDX_SRC_LIVE: rd_mux = 8'(live);
      `IDX_SRC_LATCH: rd_mux = int_cfg_reg.latch_unmasked_only ?
        8'(latch_reg & ~mask_reg) : 8'(latch_reg);
      `IDX_SRC_MASK: rd_mux = 8'(mask_reg);
      `IDX_PWR_CTRL: rd_mux = {6'h00, dac_pd_reg, adc_pd_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // read channel, one read at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= ar_ok ? {24'h000000, rd_mux} : 32'h0000_0000;
        s_axi_rresp <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // fault decisions; reserved selector behaves like none
  always_comb begin
    dac_trig = DAC_GRP;
    if (dac_cfg_reg.pu_mask && pu_sync_reg) begin
      dac_trig[`SRC_DAC_GATE] = 1'b0;
    end
    case (int_cfg_reg.adc_sel)
      fault_irq_pkg::PD_UNMASKED: adc_flt = |(live & ~mask_reg & ADC_GRP);
      fault_irq_pkg::PD_ALL: adc_flt = |(live & ADC_GRP);
      default: adc_flt = 1'b0;
    endcase
    case (dac_cfg_reg.sel)
      fault_irq_pkg::PD_UNMASKED: dac_flt = |(live & ~mask_reg & dac_trig);
      fault_irq_pkg::PD_ALL: dac_flt = |(live & dac_trig);
      default: dac_flt = 1'b0;
    endcase
  end

  // power-down holds; manual recovery needs a restart write after the fault is gone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adc_pd_reg <= 1'b0;
      dac_pd_reg <= 1'b0;
    end else if (ce) begin
      if (adc_flt) begin
        adc_pd_reg <= 1'b1;
      end else if (!int_cfg_reg.adc_manual || adc_restart) begin
        adc_pd_reg <= 1'b0;
      end
      if (dac_flt) begin
        dac_pd_reg <= 1'b1;
      end else if (!dac_cfg_reg.manual || dac_restart) begin
        dac_pd_reg <= 1'b0;
      end
    end
  end

  // interrupt conditions
  assign lat_any = |(latch_reg & ~mask_reg);
  assign live_any = |(live & ~mask_reg);
  assign new_evt = |(live & ~live_d_reg & ~mask_reg);

  // pulse sequencer for the timed modes
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      fault_irq_pkg::ST_IDLE: begin
        if ((int_cfg_reg.mode == fault_irq_pkg::IRQ_REPEAT && lat_any) ||
            (int_cfg_reg.mode == fault_irq_pkg::IRQ_ONESHOT && new_evt)) begin
          st_next = fault_irq_pkg::ST_ON;
        end
      end
      fault_irq_pkg::ST_ON: begin
        if (int_cfg_reg.mode == fault_irq_pkg::IRQ_ONESHOT) begin
          if (cnt_reg == PULSE_END && !new_evt) begin
            st_next = fault_irq_pkg::ST_IDLE;
          end
        end else if (int_cfg_reg.mode != fault_irq_pkg::IRQ_REPEAT) begin
          st_next = fault_irq_pkg::ST_IDLE;
        end else if (cnt_reg == PULSE_END) begin
          st_next = fault_irq_pkg::ST_OFF;
        end
      end
      fault_irq_pkg::ST_OFF: begin
        if (int_cfg_reg.mode != fault_irq_pkg::IRQ_REPEAT) begin
          st_next = fault_irq_pkg::ST_IDLE;
        end else if (cnt_reg == PERIOD_END) begin
          st_next = lat_any ? fault_irq_pkg::ST_ON : fault_irq_pkg::ST_IDLE;
        end
      end
      default: st_next = fault_irq_pkg::ST_IDLE;
    endcase
  end

  // one counter spans the whole 4 ms period; a new event restarts a one-shot pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= fault_irq_pkg::ST_IDLE;
      cnt_reg <= 20'h00000;
    end else if (ce) begin
      st_reg <= st_next;
      if (st_next == fault_irq_pkg::ST_IDLE) begin
        cnt_reg <= 20'h00000;
      end else if (st_reg == fault_irq_pkg::ST_IDLE) begin
        cnt_reg <= 20'h00000;
      end else if (int_cfg_reg.mode == fault_irq_pkg::IRQ_ONESHOT && new_evt) begin
        cnt_reg <= 20'h00000;
      end else if (cnt_reg == PERIOD_END) begin
        cnt_reg <= 20'h00000;
      end else begin
        cnt_reg <= cnt_reg + 20'h00001;
      end
    end
  end

  // mode select for the active level of the pin
  always_comb begin
    case (int_cfg_reg.mode)
      fault_irq_pkg::IRQ_LATCHED: irq_active = lat_any;
      fault_irq_pkg::IRQ_LIVE: irq_active = live_any;
      default: irq_active = (st_next == fault_irq_pkg::ST_ON);
    endcase
  end

  // registered outputs; the pin idles high at reset because low is active by default
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_pin <= 1'b1;
      irq_level <= 1'b0;
      adc_powerdown <= 1'b0;
      micbias_powerdown <= 1'b0;
      dac_powerdown <= 1'b0;
    end else if (ce) begin
      irq_pin <= int_cfg_reg.pol ? irq_active : ~irq_active;
      irq_level <= lat_any;
      adc_powerdown <= adc_pd_reg;
      micbias_powerdown <= adc_pd_reg;
      dac_powerdown <= dac_pd_reg;
    end
  end
endmodule

// >>> test/fault_irq_asserts.sv
// port-level checks for the fault interrupt and power-down block
`timescale 1ns/1ps
module fault_irq_asserts #(
  parameter int N_SRC = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_SRC-1:0] src_fault_in,
  input wire logic [5:0] frame_ratio_upper_bits,
  input wire logic [7:0] frame_ratio_lower_bits,
  input wire logic irq_pin,
  input wire logic irq_level,
  input wire logic adc_powerdown,
  input wire logic micbias_powerdown,
  input wire logic dac_powerdown
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic ar_take;
  logic ar_map;
  logic [3:0] adc_age;
  logic [3:0] dac_age;
  // read handshakes and whether the address hits the register map
  assign ar_take = s_axi_arvalid && s_axi_arready && ce;
  assign ar_map = s_axi_araddr >= 10'h100 && s_axi_araddr <= 10'h11c && s_axi_araddr[1:0] == 2'h0;
  // cycles since a raw fault line was seen; a power-down must have a recent cause
  always_ff @(posedge clk) begin
    if (sys_rst || src_fault_in[1:0] != 2'h0) adc_age <= 4'h0;
    else if (adc_age != 4'hf) adc_age <= adc_age + 4'h1;
    if (sys_rst || src_fault_in[3:2] != 2'h0) dac_age <= 4'h0;
    else if (dac_age != 4'hf) dac_age <= dac_age + 4'h1;
  end
  AST_RESET_IDLE: assert property ($fell(sys_rst) |-> irq_pin && !irq_level &&
    !adc_powerdown && !dac_powerdown) else $error("outputs not idle after reset");
  AST_MICBIAS_WITH_ADC: assert property (adc_powerdown == micbias_powerdown)
    else $error("mic bias power-down differs from adc");
  AST_ADC_CAUSE: assert property ($rose(adc_powerdown) |-> adc_age < 4'h8)
    else $error("adc powered down without a fault");
  AST_DAC_CAUSE: assert property ($rose(dac_powerdown) |-> dac_age < 4'h8)
    else $error("dac powered down without a fault");
  AST_RATIO_LOWER: assert property (ar_take && s_axi_araddr == 10'h104 |=>
    s_axi_rdata == {24'h0, $past(frame_ratio_lower_bits)}) else $error("ratio byte wrong");
  AST_RATIO_UPPER: assert property (ar_take && s_axi_araddr == 10'h100 |=>
    s_axi_rdata == {26'h0, $past(frame_ratio_upper_bits)}) else $error("ratio bits wrong");
  AST_DOWN_FLAG: assert property (ar_take && s_axi_araddr == 10'h10c |=>
    s_axi_rdata[3] == $past(dac_powerdown)) else $error("dac down flag wrong");
  AST_READ_RESP: assert property (ar_take |=> s_axi_rvalid &&
    s_axi_rresp == ($past(ar_map) ? 2'h0 : 2'h2)) else $error("read answer late or wrong");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind fault_interrupt_powerdown_ctrl fault_irq_asserts #(.N_SRC(N_SRC)) chk_i (.clk, .sys_rst,
  .ce, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .src_fault_in, .frame_ratio_upper_bits,
  .frame_ratio_lower_bits, .irq_pin, .irq_level, .adc_powerdown, .micbias_powerdown,
  .dac_powerdown);

// >>> test/fault_source_model.sv
// analog fault sensor model driving the live fault lines
`timescale 1ns/1ps
module fault_source_model (
  input wire logic clk,
  input wire logic [7:0] fault_cmd,
  input wire logic pwrup_cmd,
  output logic [7:0] src_fault_in,
  output logic dac_powering_up_in
);
  initial src_fault_in = 8'h0;
  initial dac_powering_up_in = 1'h0;
  // sensors are not clocked, so lines move 3 ns after the edge
  always @(posedge clk) begin
    src_fault_in <= #3 fault_cmd;
    dac_powering_up_in <= #3 pwrup_cmd;
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the fault interrupt and power-down block
`timescale 1ns/1ps
`include "fault_irq_map.svh"
module tb_top;
  localparam logic [9:0] UP = {`IDX_RATIO_UPPER, 2'h0};
  localparam logic [9:0] LO = {`IDX_RATIO_LOWER, 2'h0};
  localparam logic [9:0] CFG = {`IDX_INT_CFG, 2'h0};
  localparam logic [9:0] DCF = {`IDX_DAC_CFG, 2'h0};
  localparam logic [9:0] LIV = {`IDX_SRC_LIVE, 2'h0};
  localparam logic [9:0] LAT = {`IDX_SRC_LATCH, 2'h0};
  localparam logic [9:0] MSK = {`IDX_SRC_MASK, 2'h0};
  localparam logic [9:0] PWR = {`IDX_PWR_CTRL, 2'h0};
  logic clk = 1'h0, sys_rst = 1'h1, ce = 1'h1, pwrup_cmd = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] fault_cmd = 8'h0, frame_ratio_lower_bits = 8'h0, rs = 8'h0f;
  logic [5:0] frame_ratio_upper_bits = 6'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] src_fault_in;
  logic dac_powering_up_in, irq_pin, irq_level, adc_powerdown, micbias_powerdown, dac_powerdown;
  logic [33:0] q[$];
  int fails = 0, samples_checked = 0;

  fault_interrupt_powerdown_ctrl #(.PULSE_CYC(4), .PERIOD_CYC(8)) uut (.clk, .sys_rst, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_fault_in,
    .dac_powering_up_in, .frame_ratio_upper_bits, .frame_ratio_lower_bits, .irq_pin,
    .irq_level, .adc_powerdown, .micbias_powerdown, .dac_powerdown);
  fault_source_model sensors (.clk, .fault_cmd, .pwrup_cmd, .src_fault_in, .dac_powering_up_in);

  always #5 clk = ~clk;

  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // unmapped or misaligned addresses are answered with an error
  function automatic logic ok(input logic [9:0] a);
    return a >= UP && a <= PWR && a[1:0] == 2'h0;
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic flt(input logic [7:0] v);
    fault_cmd <= v;
    wt(8);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic aw, w;
    q.push_back({ok(a) ? `RESP_OKAY : `RESP_SLVERR, 32'h0});
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // each channel is released at the edge where it is taken
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
    end while (!(aw && w));
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d);
    q.push_back(ok(a) ? {`RESP_OKAY, 24'h0, d} : {`RESP_SLVERR, 32'h0});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t pin level %b", $time, g);
    end
  endtask
  // counts active pin cycles; pin is active high in these scenarios
  task automatic hi(input int n, input int e);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c = c + int'(irq_pin === 1'h1);
    end
    samples_checked++;
    if (c != e) begin
      fails++;
      $display("FAIL %0t pin active %0d cycles", $time, c);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // takes the oldest note at each bus answer
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready) begin
      samples_checked++;
      if ((s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}) !== q.pop_front())
      begin
        fails++;
        $display("FAIL %0t bus answer %h", $time, s_axi_rdata);
      end
    end
  end

  // the run needs about 700 cycles
  initial begin
    wt(20000);
    fails++;
    summarize();
  end

  initial begin
    wt(20);
    sys_rst <= 1'h0;
    wt(2);
    chk(irq_pin, 1'h1);
    rd(LO, `RATIO_LOWER_RST);
    rd(CFG, `INT_CFG_RST);
    rd(DCF, `DAC_CFG_RST);
    rd(MSK, `SRC_MASK_RST);
    // random ratio inputs and config values; bit 3 of the dac config reads back zero
    repeat (3) begin
      rs = nx(rs);
      frame_ratio_upper_bits <= rs[5:0];
      frame_ratio_lower_bits <= ~rs;
      rd(UP, {2'h0, rs[5:0]});
      rd(LO, ~rs);
      wr(DCF, rs & 8'h7f);
      rd(DCF, rs & `DAC_CFG_WMASK);
      wr(CFG, rs);
      rd(CFG, rs);
    end
    wr(LO, 8'ha5);
    rd(LO, ~rs);
    rd(10'h120, 8'h0);
    wr(10'h120, 8'h0);
    rd(10'h109, 8'h0);
    s_axi_wstrb <= 4'he;
    wr(CFG, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd(CFG, rs);
    wr(CFG, 8'h00);
    wr(DCF, `DAC_CFG_RST);
    // interrupt pin modes, polarity and masking
    flt(8'h20);
    chk(irq_pin, 1'h0);
    chk(irq_level, 1'h1);
    rd(LIV, 8'h20);
    rd(LAT, 8'h20);
    wr(CFG, 8'h80);
    wt(3);
    chk(irq_pin, 1'h1);
    wr(MSK, 8'h20);
    wt(3);
    chk(irq_pin, 1'h0);
    wr(CFG, 8'h84);
    rd(LAT, 8'h00);
    wr(CFG, 8'h80);
    rd(LAT, 8'h20);
    wr(MSK, 8'h00);
    flt(8'h00);
    wr(CFG, 8'ha0);
    wt(3);
    chk(irq_pin, 1'h0);
    wr(CFG, 8'h80);
    wt(3);
    chk(irq_pin, 1'h1);
    wr(CFG, 8'hc0);
    wt(2);
    hi(16, 8);
    rd(LAT, 8'h20);
    wt(4);
    hi(16, 0);
    wr(CFG, 8'he0);
    fault_cmd <= 8'h20;
    hi(24, 4);
    fault_cmd <= 8'h00;
    wt(4);
    fault_cmd <= 8'h20;
    hi(24, 4);
    flt(8'h00);
    // adc selector codes with the source masked and unmasked, auto recovery
    for (int i = 0; i < 8; i++) begin
      wr(MSK, {7'h0, i[0]});
      wr(CFG, {3'h0, i[2:1], 3'h0});
      flt(8'h01);
      chk(adc_powerdown, i[2:1] == 2'h2 || i[2:1] == 2'h1 && !i[0]);
      chk(micbias_powerdown, i[2:1] == 2'h2 || i[2:1] == 2'h1 && !i[0]);
      flt(8'h00);
      chk(adc_powerdown, 1'h0);
    end
    wr(CFG, 8'h12);
    flt(8'h01);
    flt(8'h00);
    chk(adc_powerdown, 1'h1);
    rd(PWR, 8'h01);
    wr(PWR, 8'h01);
    wt(4);
    chk(adc_powerdown, 1'h0);
    // dac held down by default until restarted
    flt(8'h04);
    flt(8'h00);
    chk(dac_powerdown, 1'h1);
    rd(DCF, 8'h58);
    wr(PWR, 8'h02);
    wt(4);
    chk(dac_powerdown, 1'h0);
    wr(DCF, 8'h54);
    pwrup_cmd <= 1'h1;
    flt(8'h04);
    chk(dac_powerdown, 1'h0);
    pwrup_cmd <= 1'h0;
    wt(8);
    chk(dac_powerdown, 1'h1);
    flt(8'h00);
    wr(PWR, 8'h02);
    wr(MSK, 8'h04);
    for (int j = 0; j < 4; j++) begin
      wr(DCF, {1'h0, j[1:0], 5'h0});
      flt(8'h04);
      chk(dac_powerdown, j == 2);
      flt(8'h00);
      chk(dac_powerdown, 1'h0);
    end
    wr(DCF, 8'h43);
    flt(8'h1c);
    chk(dac_powerdown, 1'h0);
    rd(LIV, 8'h00);
    wr(DCF, 8'h40);
    wt(6);
    rd(LIV, 8'h1c);
    chk(dac_powerdown, 1'h1);
    flt(8'h00);
    // clock enable low freezes the fault chain; it resumes once enabled again
    ce <= 1'h0;
    flt(8'h01);
    chk(adc_powerdown, 1'h0);
    ce <= 1'h1;
    wt(8);
    chk(adc_powerdown, 1'h1);
    wt(4);
    summarize();
  end
endmodule
